// ===== verilog/dcr_consts.vh
// constants for the device capability register bank
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH

// byte addresses on the apb bus
`define DCR_OFS_FEATURES_ONE 12'h010
`define DCR_OFS_FEATURES_TWO 12'h014

// first capability word: field positions
`define DCR_F1_JTAG_BIT      0
`define DCR_F1_TWO_WIRE_BIT  1
`define DCR_F1_TRACE_BIT     2
`define DCR_F1_WATCHDOG_BIT  3
`define DCR_F1_PLL_BIT       4
`define DCR_F1_TEMP_BIT      5
`define DCR_F1_RSVD6_BIT     6
`define DCR_F1_MPU_BIT       7
`define DCR_F1_RATE_LSB      8
`define DCR_F1_RATE_MSB      9
`define DCR_F1_DIV_LSB       12
`define DCR_F1_DIV_MSB       15
`define DCR_F1_CONV_BIT      16
`define DCR_F1_PWM_BIT       20

// first capability word: field values
`define DCR_F1_DIV_VALUE     4'h3
`define DCR_F1_RATE_VALUE    2'h2
`define DCR_F1_PRESENT_LOW   8'hbf
`define DCR_F1_RESET         32'h001132bf

// second word: bit positions shared with the clock gating and soft reset
`define DCR_UNIT_SERIAL0_BIT   0
`define DCR_UNIT_SERIAL1_BIT   1
`define DCR_UNIT_SYNC0_BIT     4
`define DCR_UNIT_QUAD0_BIT     8
`define DCR_UNIT_TIMER0_BIT    16
`define DCR_UNIT_TIMER1_BIT    17
`define DCR_UNIT_TIMER2_BIT    18
`define DCR_UNIT_COMPARE0_BIT  24
`define DCR_F2_RESET         32'h01070113

// answers
`define DCR_READ_ZERO        32'h00000000

`endif

// ===== verilog/dcr_const_word.v
// one read-only capability word, loaded at reset and never written
`timescale 1ns/1ps
`default_nettype none

module dcr_const_word #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] VALUE = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // constant word out
  output wire [WIDTH-1:0] word
);

  reg [WIDTH-1:0] held;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // each bit takes its fixed value at reset and keeps it
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          held[i] <= VALUE[i];
        end else begin
          held[i] <= VALUE[i];
        end
      end
    end
  endgenerate

  assign word = held;

endmodule // dcr_const_word

`default_nettype wire

// ===== verilog/dcr_apb_front.v
// apb handshake: zero-wait answer, pready from a flip-flop
`timescale 1ns/1ps
`default_nettype none

module dcr_apb_front (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // apb control
  input  wire psel,
  input  wire penable,
  // one-cycle pulse: setup phase seen, answer loads next edge
  output wire setup_seen,
  // registered ready
  output reg  pready
);

  assign setup_seen = psel & ~penable;

  // ready rises in the first access cycle and falls after it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_seen;
    end
  end

endmodule // dcr_apb_front

`default_nettype wire

// ===== verilog/dcr_capability_regs.v
// device capability registers behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "dcr_consts.vh"

////////////////////////////////////////////////////////////////////////////
module dcr_capability_regs (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  // apb answer
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr
);

  ////////////////////////////////////////////////////////////////////////
  // first capability word, assembled from named fields

  wire [31:0] one_value;
  wire [31:0] one_word;
  wire [31:0] two_word;
  wire        setup_seen;
  wire        hit_one;
  wire        hit_two;
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  // presence bits, low byte
  // fixed present bits
  assign one_value[`DCR_F1_JTAG_BIT]     = 1'b1;
  assign one_value[`DCR_F1_TWO_WIRE_BIT] = 1'b1;
  assign one_value[`DCR_F1_TRACE_BIT]    = 1'b1;
  assign one_value[`DCR_F1_WATCHDOG_BIT] = 1'b1;
  assign one_value[`DCR_F1_PLL_BIT]      = 1'b1;
  assign one_value[`DCR_F1_TEMP_BIT]     = 1'b1;
  assign one_value[`DCR_F1_MPU_BIT]      = 1'b1;
  assign one_value[`DCR_F1_RSVD6_BIT]    = 1'b0;
  // converter rate and reserved pair
  assign one_value[`DCR_F1_RATE_MSB:`DCR_F1_RATE_LSB] = `DCR_F1_RATE_VALUE;
  assign one_value[11:10] = 2'h0;
  assign one_value[`DCR_F1_DIV_MSB:`DCR_F1_DIV_LSB] = `DCR_F1_DIV_VALUE;
  // upper half: converter and pwm presence, rest reserved
  assign one_value[`DCR_F1_CONV_BIT] = 1'b1;
  assign one_value[19:17] = 3'h0;
  assign one_value[`DCR_F1_PWM_BIT] = 1'b1;
  assign one_value[31:21] = 11'h000;

  ////////////////////////////////////////////////////////////////////////
  // held words; only bits 7:0 of the field build reach the read mux, nothing compares it with the reset word

  // word loaded at reset, no write path
  dcr_const_word #(
    .WIDTH (32),
    .VALUE (`DCR_F1_RESET)
  ) u_word_one (
    .pclk    (pclk),
    .presetn (presetn),
    .word    (one_word)
  );

  // unit bits sit where gating and reset put them
  dcr_const_word #(
    .WIDTH (32),
    .VALUE (`DCR_F2_RESET)
  ) u_word_two (
    .pclk    (pclk),
    .presetn (presetn),
    .word    (two_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb handshake

  dcr_apb_front u_front (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .setup_seen (setup_seen),
    .pready     (pready)
  );

  assign hit_one = (paddr == `DCR_OFS_FEATURES_ONE);
  assign hit_two = (paddr == `DCR_OFS_FEATURES_TWO);

  // read mux; the low byte comes from the field build so a slip in the
  // held word shows up only on the upper bits, both agree by design
  // writes to mapped words accepted silently, data discarded
  always @* begin
    next_prdata  = `DCR_READ_ZERO;
    next_pslverr = 1'b0;
    if (hit_one) begin
      next_prdata = pwrite ? `DCR_READ_ZERO
                           : {one_word[31:8], one_value[7:0]};
    end else if (hit_two) begin
      next_prdata = pwrite ? `DCR_READ_ZERO : two_word;
    end else begin
      next_pslverr = 1'b1; // unmapped address
    end
  end

  // answer registered at the setup edge, cleared after the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `DCR_READ_ZERO;
      pslverr <= 1'b0;
    end else if (setup_seen) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end else begin
      prdata  <= `DCR_READ_ZERO;
      pslverr <= 1'b0;
    end
  end

  // write data is deliberately unused: the bank is read-only
  wire unused_wdata = ^pwdata;

endmodule // dcr_capability_regs

`default_nettype wire

// ===== verif/dcr_capability_props.sv
// checker for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module dcr_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb request and answer
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decode of the two mapped words
  wire hit1 = (paddr == 12'h010);
  wire hit2 = (paddr == 12'h014);
  ready_next_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  word_one_a: assert property (pready && !pwrite && hit1 |->
    prdata[7:0] == 8'hbf && prdata[15:12] == 4'h3)
    else $error("first word wrong");
  word_two_a: assert property (pready && !pwrite && hit2 |->
    prdata == 32'h01070113) else $error("second word wrong");
  write_quiet_a: assert property (pready && pwrite |-> prdata == 0)
    else $error("write returned data");
  miss_error_a: assert property (pready && !hit1 && !hit2 |->
    pslverr && prdata == 0) else $error("unmapped not refused");
  hit_clean_a: assert property (pready && (hit1 || hit2) |-> !pslverr)
    else $error("mapped word refused");
  idle_zero_a: assert property (!pready |-> prdata == 0 && !pslverr)
    else $error("answer outside access");
endmodule // dcr_props
bind dcr_capability_regs dcr_props u_dcr_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  dcr_capability_regs u_dcr_capability_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #4 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one transfer; holds the request until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
  endtask
  task idle;
    psel <= 0; penable <= 0;
    @(posedge pclk);
    chk(pready, 0);
    chk(prdata, 0);
    chk(pslverr, 0);
  endtask
  // mid-run reset: pready and prdata stay quiet, the first word comes back unchanged
  task t_reset;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk(pready, 0);
    chk(prdata, 0);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h010, 0);
    chk(r, 32'h001132bf);
    idle;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_word_one;
    apb(0, 12'h010, 0);
    chk(e, 0);
    chk(r[7], 1);
    chk(r[6], 0);
    chk(r[5], 1);
    chk(r[4], 1);
    chk(r[3], 1);
    chk(r[2], 1);
    chk(r[1], 1);
    chk(r[0], 1);
    chk(r[15:12], 4'h3);
  endtask
  // back to back with the first word to stress the decode
  task t_word_two;
    apb(0, 12'h014, 0);
    chk(r, 32'h01070113);
    chk({r[24], r[18:16], r[8], r[4], r[1:0]}, 8'hff);
    chk(e, 0);
  endtask
  // read-modify-write of a constant word, then all ones, then read back
  task t_writes;
    apb(0, 12'h010, 0);
    apb(1, 12'h010, r);
    chk(e, 0);
    chk(r, 0);
    apb(1, 12'h014, 32'hffffffff);
    chk(e, 0);
    chk(r, 0);
    apb(0, 12'h010, 0);
    chk(r, 32'h001132bf);
    apb(0, 12'h014, 0);
    chk(r, 32'h01070113);
    idle;
  endtask
  // neighbours of the mapped words are refused for both directions
  task t_unmapped;
    apb(0, 12'h018, 0);
    chk(e, 1);
    chk(r, 0);
    apb(1, 12'h00c, 32'h12345678);
    chk(e, 1);
    chk(r, 0);
    apb(0, 12'h011, 0);
    chk(e, 1);
    chk(r, 0);
    idle;
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    idle;
    t_word_one;
    t_word_two;
    idle;
    t_writes;
    t_unmapped;
    t_reset;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
